// ---- shared/uir_regs.vh ----
/*
 * Select codes, field positions and reset values for the information
 * register read unit.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef UIR_REGS_VH
`define UIR_REGS_VH

// ------------------------------------------------------------
// Register select codes
// ------------------------------------------------------------
`define UIR_SEL_CPU_IDENTITY 5'h00
`define UIR_SEL_CACHE_SYNC_STEP 5'h01
`define UIR_SEL_TICK_COUNTER 5'h02
`define UIR_SEL_TICK_RESOLUTION 5'h03
`define UIR_SEL_RSVD_LO 5'h04
`define UIR_SEL_RSVD_HI 5'h1c
`define UIR_SEL_THREAD_POINTER_VIEW 5'h1d
`define UIR_SEL_IMPL_A 5'h1e
`define UIR_SEL_IMPL_B 5'h1f

// ------------------------------------------------------------
// Field layout and reset values
// ------------------------------------------------------------
`define UIR_SEL_W 5
`define UIR_GPR_W 5
`define UIR_CPU_ID_LSB 0
`define UIR_CPU_ID_W 10
`define UIR_DATA_RST 32'h0000_0000
`define UIR_ADDR_RST 5'h00
`define UIR_CACHE_SYNC_STEP_DFLT 32'h0000_0020
`define UIR_TICK_RESOLUTION_DFLT 32'h0000_0002

`endif

// ---- rtl/uir_read_unit.v ----
/*
 * Information register read unit: executes the read_info_register_op
 * instruction, selecting one information register by a 5-bit select
 * field and returning it for write-back to the destination GPR, or
 * raising a Reserved Instruction exception.
 * Assumes the pipeline presents one instruction per op_valid pulse with
 * all operands stable in that cycle, and that coprocessor 0 sources are
 * on the same clock.
 */
//
// Behaviour
// - Permitted access copies the selected register to the destination GPR.
// - Access permitted when coprocessor 0 usable or the mask bit is set.
// - Denied or unimplemented access raises Reserved Instruction, no GPR write.
// - Select 0 returns the CPU identity from the exception base field.
// - Select 1 returns the icache sync step, zero if none needed.
// - Select 2 returns the coprocessor 0 cycle count register.
// - Select 3 returns cycles between cycle counter increments.
// - Selects 4 to 28 are reserved and raise Reserved Instruction.
// - Select 29 returns the thread pointer when implemented, else unimplemented.
// - Selects 30 and 31 are implementation values, else Reserved Instruction.
// - A first-release-only processor treats the instruction as reserved.
`timescale 1ns/1ns
`include "uir_regs.vh"

module uir_read_unit #(
    parameter [31:0] CACHE_SYNC_STEP = `UIR_CACHE_SYNC_STEP_DFLT,
    parameter [31:0] TICK_RESOLUTION = `UIR_TICK_RESOLUTION_DFLT,
    parameter THREAD_POINTER_IMPL = 1,
    parameter IMPL_A_IMPL = 0,
    parameter IMPL_B_IMPL = 0,
    parameter [31:0] IMPL_A_VALUE = 32'h0000_0000,
    parameter [31:0] IMPL_B_VALUE = 32'h0000_0000,
    parameter RELEASE1_ONLY = 0
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Instruction issue
    input wire op_valid,
    input wire [4:0] op_select,
    input wire [4:0] dest_gpr_field,
    // Coprocessor 0 state
    input wire cp0_usable,
    input wire [31:0] user_access_enable_mask,
    input wire [9:0] exception_base_cpu_id,
    input wire [31:0] tick_counter,
    input wire [31:0] thread_pointer_source,
    // Write-back and exception
    output reg gpr_we_r,
    output reg [4:0] gpr_addr_r,
    output reg [31:0] gpr_data_r,
    output reg rsvd_instr_exc_r
);

// ------------------------------------------------------------
// Release gate
// ------------------------------------------------------------
wire release_ok;

assign release_ok = (RELEASE1_ONLY == 0);

// ------------------------------------------------------------
// Select decode
// ------------------------------------------------------------
wire [31:0] sel_hot;

assign sel_hot = 32'h0000_0001 << op_select;

// ------------------------------------------------------------
// Per-select entries
// ------------------------------------------------------------
wire [31:0] entry_data [0:31];
wire [31:0] entry_impl;
wire [31:0] entry_grant;
wire [31:0] entry_hit;

genvar k;
generate
    for (k = 0; k < 32; k = k + 1) begin : g_entry
        assign entry_grant[k] = cp0_usable | user_access_enable_mask[k];
        assign entry_hit[k] = sel_hot[k] & entry_grant[k] & entry_impl[k];
        if (k == `UIR_SEL_CPU_IDENTITY) begin : g_cpu_identity
            assign entry_data[k] = {22'h000000, exception_base_cpu_id};
            assign entry_impl[k] = 1'b1;
        end else if (k == `UIR_SEL_CACHE_SYNC_STEP) begin : g_cache_sync_step
            assign entry_data[k] = CACHE_SYNC_STEP;
            assign entry_impl[k] = 1'b1;
        end else if (k == `UIR_SEL_TICK_COUNTER) begin : g_tick_counter
            assign entry_data[k] = tick_counter;
            assign entry_impl[k] = 1'b1;
        end else if (k == `UIR_SEL_TICK_RESOLUTION) begin : g_tick_resolution
            assign entry_data[k] = TICK_RESOLUTION;
            assign entry_impl[k] = 1'b1;
        end else if (k == `UIR_SEL_THREAD_POINTER_VIEW) begin : g_thread_pointer_view
            assign entry_data[k] = thread_pointer_source;
            assign entry_impl[k] = (THREAD_POINTER_IMPL != 0);
        end else if (k == `UIR_SEL_IMPL_A) begin : g_impl_a
            assign entry_data[k] = IMPL_A_VALUE;
            assign entry_impl[k] = (IMPL_A_IMPL != 0);
        end else if (k == `UIR_SEL_IMPL_B) begin : g_impl_b
            assign entry_data[k] = IMPL_B_VALUE;
            assign entry_impl[k] = (IMPL_B_IMPL != 0);
        end else begin : g_reserved
            assign entry_data[k] = `UIR_DATA_RST;
            assign entry_impl[k] = 1'b0;
        end
    end
endgenerate

// ------------------------------------------------------------
// Selection and permission
// ------------------------------------------------------------
wire [31:0] sel_data;
wire take_nxt;
wire exc_nxt;
wire [4:0] gpr_addr_nxt;
wire [31:0] gpr_data_nxt;

assign sel_data = entry_data[op_select];
assign take_nxt = op_valid & (|entry_hit) & release_ok;
assign exc_nxt = op_valid & ~take_nxt;
assign gpr_addr_nxt = take_nxt ? dest_gpr_field : gpr_addr_r;
assign gpr_data_nxt = take_nxt ? sel_data : gpr_data_r;

// ------------------------------------------------------------
// Write strobe and exception registers
// ------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        gpr_we_r <= 1'b0;
    end else begin
        gpr_we_r <= take_nxt;
    end
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        rsvd_instr_exc_r <= 1'b0;
    end else begin
        rsvd_instr_exc_r <= exc_nxt;
    end
end

// ------------------------------------------------------------
// Write-back registers
// ------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        gpr_addr_r <= `UIR_ADDR_RST;
    end else begin
        gpr_addr_r <= gpr_addr_nxt;
    end
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        gpr_data_r <= `UIR_DATA_RST;
    end else begin
        gpr_data_r <= gpr_data_nxt;
    end
end

endmodule // uir_read_unit

// ---- dv/uir_monitor.sv ----
/* Checker of the read unit ports. Assumes it is bound to the unit. */
`timescale 1ns/1ns
module uir_monitor (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Instruction issue
    input wire op_valid,
    input wire [4:0] op_select,
    input wire [4:0] dest_gpr_field,
    // Coprocessor 0 state
    input wire cp0_usable,
    input wire [31:0] user_access_enable_mask,
    input wire [9:0] exception_base_cpu_id,
    input wire [31:0] tick_counter,
    input wire [31:0] thread_pointer_source,
    // Write-back and exception
    input wire gpr_we_r,
    input wire [4:0] gpr_addr_r,
    input wire [31:0] gpr_data_r,
    input wire rsvd_instr_exc_r
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!reset_n);
wire ok = op_valid & (cp0_usable | user_access_enable_mask[op_select]);
property p_one; op_valid |=> gpr_we_r != rsvd_instr_exc_r; endproperty
a_one: assert property (p_one) else $error("one");
property p_deny; op_valid && !ok |=> rsvd_instr_exc_r; endproperty
a_deny: assert property (p_deny) else $error("deny");
property p_rsv; op_valid && op_select > 5'h03 && op_select < 5'h1d |=> rsvd_instr_exc_r;
endproperty
a_rsv: assert property (p_rsv) else $error("rsv");
property p_top; op_valid && op_select > 5'h1d |=> rsvd_instr_exc_r; endproperty
a_top: assert property (p_top) else $error("top");
property p_id; ok && op_select == 5'h00 |=> gpr_data_r == {22'h0, $past(exception_base_cpu_id)};
endproperty
a_id: assert property (p_id) else $error("id");
property p_cc; ok && op_select == 5'h02 |=> gpr_data_r == $past(tick_counter)
    && gpr_addr_r == $past(dest_gpr_field); endproperty
a_cc: assert property (p_cc) else $error("cc");
property p_ulr; ok && op_select == 5'h1d |=> gpr_data_r == $past(thread_pointer_source);
endproperty
a_ulr: assert property (p_ulr) else $error("ulr");
property p_keep; rsvd_instr_exc_r |-> $stable(gpr_data_r) && !gpr_we_r; endproperty
a_keep: assert property (p_keep) else $error("keep");
c_cc: cover property (ok && op_select == 5'h02);
c_deny: cover property (op_valid && !ok);
c_b2b: cover property (rsvd_instr_exc_r ##1 gpr_we_r);
endmodule // uir_monitor
bind uir_read_unit uir_monitor uir_monitor_inst (.*);

// ---- dv/uir_cp0.sv ----
/* Coprocessor 0 count model. Assumes the bench clock and reset. */
`timescale 1ns/1ns
module uir_cp0 #(
    parameter RES = 2
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Count register
    output reg [31:0] tick_counter
);
integer n;
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tick_counter <= 32'hffff_fff0;
        n <= 0;
    end else begin
        n <= (n == RES - 1) ? 0 : n + 1;
        if (n == RES - 1) tick_counter <= tick_counter + 32'h1;
    end
end
endmodule // uir_cp0

// ---- dv/test_user_info_register_read_unit.sv ----
/* Bench of the read unit. Assumes default unit parameters. */
`timescale 1ns/1ns
`include "uir_regs.vh"
module test_user_info_register_read_unit;
reg clk_sys = 0, reset_n = 0, op_valid = 0, cp0_usable = 0, ew = 0, ex = 0, g;
reg [4:0] op_select = 0, dest_gpr_field = 0, ea = 0, s;
reg [9:0] exception_base_cpu_id = 0;
reg [31:0] user_access_enable_mask = 0, thread_pointer_source = 0, ed = 0, d;
wire [31:0] tick_counter, gpr_data_r;
wire [4:0] gpr_addr_r;
wire gpr_we_r, rsvd_instr_exc_r;
integer err_total = 0, samples_checked = 0, i, sd;
uir_read_unit uir_read_unit_inst (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .op_valid(op_valid),
    .op_select(op_select),
    .dest_gpr_field(dest_gpr_field),
    .cp0_usable(cp0_usable),
    .user_access_enable_mask(user_access_enable_mask),
    .exception_base_cpu_id(exception_base_cpu_id),
    .tick_counter(tick_counter),
    .thread_pointer_source(thread_pointer_source),
    .gpr_we_r(gpr_we_r),
    .gpr_addr_r(gpr_addr_r),
    .gpr_data_r(gpr_data_r),
    .rsvd_instr_exc_r(rsvd_instr_exc_r)
);
uir_cp0 uir_cp0_inst (.clk_sys(clk_sys), .reset_n(reset_n), .tick_counter(tick_counter));
initial forever #25 clk_sys = ~clk_sys;
task chk(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        err_total++;
        $display("BAD %0t got %h want %h", $time, seen, exp);
    end
endtask
task end_sim;
    $display("compares %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
initial begin
    sd = $urandom(32'h92a9);
    repeat (5) @(negedge clk_sys);
    reset_n = 1;
    for (i = 0; i < 500; i++) begin
        if (i == 400) begin
            op_valid = 0;
            reset_n = 0;
            @(negedge clk_sys);
            chk(gpr_we_r, 0);
            chk(rsvd_instr_exc_r, 0);
            chk(gpr_addr_r, 0);
            chk(gpr_data_r, 0);
            ea = 0;
            ed = 0;
            reset_n = 1;
            $display("reset test done");
        end
        op_valid = i < 32 || $urandom_range(1);
        cp0_usable = i < 32 || $urandom_range(3) == 0;
        op_select = i < 32 ? i[4:0] : $urandom_range(31);
        dest_gpr_field = $urandom_range(31);
        user_access_enable_mask = $urandom;
        exception_base_cpu_id = $urandom_range(1023);
        thread_pointer_source = $urandom;
        s = op_select;
        case (s)
            `UIR_SEL_CPU_IDENTITY: d = {22'h0, exception_base_cpu_id};
            `UIR_SEL_CACHE_SYNC_STEP: d = `UIR_CACHE_SYNC_STEP_DFLT;
            `UIR_SEL_TICK_COUNTER: d = tick_counter;
            `UIR_SEL_TICK_RESOLUTION: d = `UIR_TICK_RESOLUTION_DFLT;
            default: d = thread_pointer_source;
        endcase
        g = op_valid && (s < 4 || s == 29) && (cp0_usable || user_access_enable_mask[s]);
        ex = op_valid && !g;
        ew = g;
        if (g) {ea, ed} = {dest_gpr_field, d};
        @(negedge clk_sys);
        chk(gpr_we_r, ew);
        chk(rsvd_instr_exc_r, ex);
        chk(gpr_addr_r, ea);
        chk(gpr_data_r, ed);
        if (i == 31) $display("select sweep done");
    end
    $display("random mix done");
    end_sim;
end
endmodule // test_user_info_register_read_unit
